// File: design/iobr_device.sv
// bridge end: io windows, translation, indirect io and subtractive decode
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one io window per interface, each direction
// - window sizes 64, 128, 256 bytes
// - larger windows are not blocked
// - upper bits replaced by translated base
// - translated bases in config and csr space
// - address/data pair only from owning interface
// - data access issues far io cycle
// - only io cycles from owner start transfers
// - generation needs direction enable bit
// - far cycle reuses initiator byte enables
// - initiator keeps address bits matching enables
// - retry data access until far cycle completes
// - request queued and ordered per direction
// - repeat gets termination and read data
// - owner read returns flag then sets it
// - initiator waits for zero, repeats until done
// - completion returned clears ownership flag
// - side-effect free copies; byte access advised
// - subtractive forward without translation, delayed
// - retries keep subtractive timing while queued
// - software never enables both interfaces
module iobr_device
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  iobr_if.dev LINK,
  output logic DN_OWN_O,
  output logic UP_OWN_O
);
  localparam int AW = iobr_pkg::AW;
  localparam int DW = iobr_pkg::DW;
  localparam int BEW = iobr_pkg::BEW;
  localparam int KW = 2 + AW + BEW + DW;

  logic [1:0][AW-1:0] bar_q;
  logic [1:0][AW-1:0] xlat_q;
  logic [1:0][AW-1:0] iaddr_q;
  logic [1:0][DW-1:0] idata_q;
  logic [1:0][iobr_pkg::SZW-1:0] wsz_q;
  logic [1:0] ioen_q;
  logic [1:0] winen_q;
  logic [1:0] own_q;
  logic [1:0] sub_q;
  logic [1:0][KW-1:0] key_q;
  logic [1:0] slot_busy;
  logic [1:0] slot_done;
  logic [1:0][DW-1:0] slot_rdata;
  logic [1:0] load;
  logic [1:0] take;
  logic d;
  logic [iobr_pkg::OFS_W-1:0] ofs;
  logic reg_acc;
  logic ind_go;
  logic fwd_win;
  logic fwd_sub;
  logic fwd;
  logic match;
  logic [AW-1:0] far_a;
  logic [AW-1:0] msk;
  logic [KW-1:0] key_now;
  logic [DW-1:0] reg_rd;
  logic req;
  logic reg_wr;

  function automatic logic [AW-1:0] win_mask(
    input logic [iobr_pkg::SZW-1:0] sz);
    win_mask = ~((32'h1 << sz) - 32'h1);
  endfunction : win_mask

  function automatic logic [7:0] data_ofs(input logic dir);
    data_ofs = dir ? iobr_pkg::OFS_UP_DATA : iobr_pkg::OFS_DN_DATA;
  endfunction : data_ofs

  function automatic logic [7:0] addr_ofs(input logic dir);
    addr_ofs = dir ? iobr_pkg::OFS_UP_ADDR : iobr_pkg::OFS_DN_ADDR;
  endfunction : addr_ofs

  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old,
    input logic [DW-1:0] nw, input logic [BEW-1:0] be);
    be_merge = old;
    for (int i = 0; i < BEW; i++)
      if (be[i])
        be_merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction : be_merge

  // subtractive decode enable for the bus a cycle came from
  function automatic logic sub_on(input logic dir, input logic [1:0] f);
    sub_on = dir ? (f == iobr_pkg::SUB_SEC) : (f == iobr_pkg::SUB_PRI);
  endfunction : sub_on

  // decode of the request now on the link
  always_comb
  begin
    d = LINK.req_side;
    ofs = LINK.req_addr[iobr_pkg::OFS_W-1:0];
    reg_acc = LINK.req_csr || (LINK.req_space == iobr_pkg::SP_CFG);
    ind_go = LINK.req_csr && (LINK.req_space == iobr_pkg::SP_IO) &&
      ioen_q[d] && (ofs == data_ofs(d));
    msk = win_mask(wsz_q[d]);
    fwd_win = !reg_acc && (LINK.req_space == iobr_pkg::SP_IO) &&
      winen_q[d] && (((LINK.req_addr ^ bar_q[d]) & msk) == '0);
    fwd_sub = !reg_acc && (LINK.req_space == iobr_pkg::SP_IO) &&
      !fwd_win && sub_on(d, sub_q);
    fwd = ind_go || fwd_win || fwd_sub;
    if (ind_go)
      far_a = iaddr_q[d];
    else if (fwd_win)
      far_a = (xlat_q[d] & msk) | (LINK.req_addr & ~msk);
    else
      far_a = LINK.req_addr;
    key_now = {ind_go, LINK.req_write, LINK.req_addr, LINK.req_be,
      LINK.req_write ? LINK.req_wdata : '0};
    match = slot_busy[d] && (key_q[d] == key_now);
  end

  assign req = LINK.req_valid && CE_I;
  assign reg_wr = req && reg_acc && LINK.req_write && !ind_go;

  // register read mux; reserved and foreign accesses read zero
  always_comb
  begin
    reg_rd = '0;
    if (ofs == iobr_pkg::OFS_DN_BAR)
      reg_rd = bar_q[iobr_pkg::DIR_DN];
    else if (ofs == iobr_pkg::OFS_UP_BAR)
      reg_rd = bar_q[iobr_pkg::DIR_UP];
    else if (ofs == iobr_pkg::OFS_DN_XLAT)
      reg_rd = xlat_q[iobr_pkg::DIR_DN];
    else if (ofs == iobr_pkg::OFS_UP_XLAT)
      reg_rd = xlat_q[iobr_pkg::DIR_UP];
    else if (ofs == addr_ofs(d))
      reg_rd = iaddr_q[d];
    else if (ofs == iobr_pkg::OFS_CTRL)
    begin
      reg_rd[iobr_pkg::CTRL_DN_EN] = ioen_q[iobr_pkg::DIR_DN];
      reg_rd[iobr_pkg::CTRL_UP_EN] = ioen_q[iobr_pkg::DIR_UP];
      reg_rd[iobr_pkg::CTRL_DN_WIN] = winen_q[iobr_pkg::DIR_DN];
      reg_rd[iobr_pkg::CTRL_UP_WIN] = winen_q[iobr_pkg::DIR_UP];
      reg_rd[iobr_pkg::CTRL_DN_OWN_RO] = own_q[iobr_pkg::DIR_DN];
      reg_rd[iobr_pkg::CTRL_UP_OWN_RO] = own_q[iobr_pkg::DIR_UP];
      reg_rd[iobr_pkg::CTRL_SUB_LO +: 2] = sub_q;
    end
    else if (ofs == iobr_pkg::OFS_OWN)
    begin
      reg_rd[iobr_pkg::OWN_DN_BIT] = own_q[iobr_pkg::DIR_DN];
      reg_rd[iobr_pkg::OWN_UP_BIT] = own_q[iobr_pkg::DIR_UP];
    end
    else if (ofs == iobr_pkg::OFS_WSIZE)
    begin
      reg_rd[iobr_pkg::SZW-1:0] = wsz_q[iobr_pkg::DIR_DN];
      reg_rd[iobr_pkg::WSZ_UP_LO +: iobr_pkg::SZW] = wsz_q[iobr_pkg::DIR_UP];
    end
  end

  // window, translation and control registers, any interface may write
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      bar_q <= '0;
      xlat_q <= '0;
      wsz_q <= {iobr_pkg::WSZ_RST, iobr_pkg::WSZ_RST};
      ioen_q <= '0;
      winen_q <= '0;
      sub_q <= '0;
    end
    else if (reg_wr)
    begin
      if (ofs == iobr_pkg::OFS_DN_BAR)
        bar_q[0] <= be_merge(bar_q[0], LINK.req_wdata, LINK.req_be);
      else if (ofs == iobr_pkg::OFS_UP_BAR)
        bar_q[1] <= be_merge(bar_q[1], LINK.req_wdata, LINK.req_be);
      else if (ofs == iobr_pkg::OFS_DN_XLAT)
        xlat_q[0] <= be_merge(xlat_q[0], LINK.req_wdata, LINK.req_be);
      else if (ofs == iobr_pkg::OFS_UP_XLAT)
        xlat_q[1] <= be_merge(xlat_q[1], LINK.req_wdata, LINK.req_be);
      else if (ofs == iobr_pkg::OFS_CTRL && LINK.req_be[0])
      begin
        ioen_q[0] <= LINK.req_wdata[iobr_pkg::CTRL_DN_EN];
        ioen_q[1] <= LINK.req_wdata[iobr_pkg::CTRL_UP_EN];
        winen_q[0] <= LINK.req_wdata[iobr_pkg::CTRL_DN_WIN];
        winen_q[1] <= LINK.req_wdata[iobr_pkg::CTRL_UP_WIN];
      end
      else if (ofs == iobr_pkg::OFS_CTRL && LINK.req_be[3])
        sub_q <= LINK.req_wdata[iobr_pkg::CTRL_SUB_LO +: 2];
      else if (ofs == iobr_pkg::OFS_WSIZE)
      begin
        if (LINK.req_be[0])
          wsz_q[0] <= LINK.req_wdata[iobr_pkg::SZW-1:0];
        if (LINK.req_be[1])
          wsz_q[1] <= LINK.req_wdata[iobr_pkg::WSZ_UP_LO +: iobr_pkg::SZW];
      end
    end
  end

  // per direction: indirect pair, ownership flag and delayed slot
  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : g_dir
      assign load[k] = req && fwd && (d == k) && !slot_busy[k];
      assign take[k] = req && fwd && (d == k) && match &&
        slot_done[k];

      // pair written only from its own interface
      always_ff @(posedge CORE_CLK_I)
      begin
        if (RST_I)
        begin
          iaddr_q[k] <= '0;
          idata_q[k] <= '0;
        end
        else if (reg_wr && d == k && ofs == addr_ofs(k))
          iaddr_q[k] <= be_merge(iaddr_q[k], LINK.req_wdata,
            LINK.req_be);
        else if (load[k] && ind_go && LINK.req_write)
          idata_q[k] <= be_merge(idata_q[k], LINK.req_wdata,
            LINK.req_be);
        else if (take[k] && ind_go && !LINK.req_write)
          idata_q[k] <= slot_rdata[k];
      end

      // only the owner's byte lane read sets the flag
      always_ff @(posedge CORE_CLK_I)
      begin
        if (RST_I)
          own_q[k] <= 1'b0;
        else if (req && reg_acc && !LINK.req_write && d == k &&
          ofs == iobr_pkg::OFS_OWN && LINK.req_be[k])
          own_q[k] <= 1'b1;
        else if (take[k] && ind_go)
          own_q[k] <= 1'b0;
      end

      // key of the queued request, matched against each repeat
      always_ff @(posedge CORE_CLK_I)
      begin
        if (RST_I)
          key_q[k] <= '0;
        else if (load[k])
          key_q[k] <= key_now;
      end

      iobr_dt_slot #(.AW(AW), .DW(DW), .BEW(BEW)) u_slot
      (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .load_i(load[k]),
        .write_i(LINK.req_write),
        .addr_i(far_a),
        .be_i(LINK.req_be),
        .wdata_i(LINK.req_wdata),
        .go_i(LINK.order_ok[k]),
        .fdone_i(LINK.far_done[k]),
        .frdata_i(LINK.far_rdata[k]),
        .take_i(take[k]),
        .busy_o(slot_busy[k]),
        .done_o(slot_done[k]),
        .rdata_o(slot_rdata[k]),
        .fvalid_o(LINK.far_valid[k]),
        .fwrite_o(LINK.far_write[k]),
        .faddr_o(LINK.far_addr[k]),
        .fbe_o(LINK.far_be[k]),
        .fwdata_o(LINK.far_wdata[k])
      );
    end
  endgenerate

  // answer one cycle after each request; forwarded cycles retry until a matching repeat finds the slot done
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_kind <= iobr_pkg::RSP_NONE;
      LINK.rsp_subtr <= 1'b0;
      LINK.rsp_rdata <= '0;
    end
    else if (CE_I)
    begin
      LINK.rsp_valid <= LINK.req_valid;
      LINK.rsp_subtr <= LINK.req_valid && fwd_sub;
      LINK.rsp_rdata <= '0;
      if (!LINK.req_valid)
        LINK.rsp_kind <= iobr_pkg::RSP_NONE;
      else if (fwd && take[d])
      begin
        LINK.rsp_kind <= iobr_pkg::RSP_DONE;
        LINK.rsp_rdata <= LINK.req_write ? '0 : slot_rdata[d];
      end
      else if (fwd)
        LINK.rsp_kind <= iobr_pkg::RSP_RETRY;
      else if (reg_acc)
      begin
        LINK.rsp_kind <= iobr_pkg::RSP_DONE;
        LINK.rsp_rdata <= LINK.req_write ? '0 : reg_rd;
      end
      else
        LINK.rsp_kind <= iobr_pkg::RSP_NONE;
    end
  end

  assign DN_OWN_O = own_q[iobr_pkg::DIR_DN];
  assign UP_OWN_O = own_q[iobr_pkg::DIR_UP];
endmodule : iobr_device
`default_nettype wire

// File: design/iobr_pkg.sv
// shared constants and types for the io window bridge and its bus agent
package iobr_pkg;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int BEW = 4;
  localparam int OFS_W = 8;
  localparam int SZW = 5;
  localparam int DIR_DN = 0;
  localparam int DIR_UP = 1;
  // bridge csr offsets, also reachable through configuration space
  localparam logic [7:0] OFS_DN_BAR = 8'h00;
  localparam logic [7:0] OFS_UP_BAR = 8'h04;
  localparam logic [7:0] OFS_DN_XLAT = 8'h08;
  localparam logic [7:0] OFS_UP_XLAT = 8'h0c;
  localparam logic [7:0] OFS_DN_ADDR = 8'h10;
  localparam logic [7:0] OFS_DN_DATA = 8'h14;
  localparam logic [7:0] OFS_UP_ADDR = 8'h18;
  localparam logic [7:0] OFS_UP_DATA = 8'h1c;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_OWN = 8'h24;
  localparam logic [7:0] OFS_WSIZE = 8'h28;
  // indirect_io_ctrl_status fields
  localparam int CTRL_DN_EN = 0;
  localparam int CTRL_UP_EN = 1;
  localparam int CTRL_DN_WIN = 2;
  localparam int CTRL_UP_WIN = 3;
  localparam int CTRL_DN_OWN_RO = 8;
  localparam int CTRL_UP_OWN_RO = 16;
  localparam int CTRL_SUB_LO = 24;
  localparam int OWN_DN_BIT = 0;
  localparam int OWN_UP_BIT = 8;
  localparam int WSZ_UP_LO = 8;
  localparam logic [4:0] WSZ_RST = 5'h06;
  localparam logic [1:0] SUB_PRI = 2'h1;
  localparam logic [1:0] SUB_SEC = 2'h2;
  // agent register offsets and fields
  localparam logic [7:0] H_ADDR = 8'h00;
  localparam logic [7:0] H_WDATA = 8'h04;
  localparam logic [7:0] H_CTRL = 8'h08;
  localparam logic [7:0] H_STAT = 8'h0c;
  localparam logic [7:0] H_RDATA = 8'h10;
  localparam logic [7:0] H_TGT = 8'h14;
  localparam logic [7:0] H_CAP = 8'h18;
  localparam logic [7:0] H_ORDER = 8'h1c;
  localparam int HC_GO = 0;
  localparam int HC_WRITE = 1;
  localparam int HC_SIDE = 2;
  localparam int HC_CSR = 3;
  localparam int HC_SPACE_LO = 4;
  localparam int HC_BE_LO = 8;
  localparam int HS_BUSY = 0;
  localparam int HS_KIND_LO = 1;
  localparam int HS_SUBTR = 3;
  localparam int FAR_LAT = 2;
  typedef enum logic [1:0] {SP_MEM = 2'h0, SP_IO = 2'h1, SP_CFG = 2'h2} space_e;
  typedef enum logic [1:0] {RSP_NONE = 2'h0, RSP_RETRY = 2'h1,
    RSP_DONE = 2'h2} rsp_e;
endpackage : iobr_pkg

// File: design/iobr_if.sv
// link between the bridge end and the bus agents end
`timescale 1ns/1ps
`default_nettype none
interface iobr_if;
  logic req_valid;
  logic req_side;
  iobr_pkg::space_e req_space;
  logic req_csr;
  logic req_write;
  logic [31:0] req_addr;
  logic [3:0] req_be;
  logic [31:0] req_wdata;
  logic rsp_valid;
  iobr_pkg::rsp_e rsp_kind;
  logic rsp_subtr;
  logic [31:0] rsp_rdata;
  logic [1:0] far_valid;
  logic [1:0] far_write;
  logic [1:0][31:0] far_addr;
  logic [1:0][3:0] far_be;
  logic [1:0][31:0] far_wdata;
  logic [1:0] far_done;
  logic [1:0][31:0] far_rdata;
  logic [1:0] order_ok;
  modport dev (input req_valid, req_side, req_space, req_csr, req_write,
    req_addr, req_be, req_wdata, far_done, far_rdata, order_ok,
    output rsp_valid, rsp_kind, rsp_subtr, rsp_rdata, far_valid, far_write,
    far_addr, far_be, far_wdata);
  modport agt (output req_valid, req_side, req_space, req_csr, req_write,
    req_addr, req_be, req_wdata, far_done, far_rdata, order_ok,
    input rsp_valid, rsp_kind, rsp_subtr, rsp_rdata, far_valid, far_write,
    far_addr, far_be, far_wdata);
endinterface : iobr_if
`default_nettype wire

// File: design/iobr_dt_slot.sv
// one delayed transaction slot: holds a request and its result until take_i after the far cycle ends
`timescale 1ns/1ps
`default_nettype none
module iobr_dt_slot
#(
  parameter int AW = 32,
  parameter int DW = 32,
  parameter int BEW = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic write_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [BEW-1:0] be_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic go_i,
  input wire logic fdone_i,
  input wire logic [DW-1:0] frdata_i,
  input wire logic take_i,
  output logic busy_o,
  output logic done_o,
  output logic [DW-1:0] rdata_o,
  output logic fvalid_o,
  output logic fwrite_o,
  output logic [AW-1:0] faddr_o,
  output logic [BEW-1:0] fbe_o,
  output logic [DW-1:0] fwdata_o
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_FAR = 2'h3,
    ST_DONE = 2'h2} slot_e;
  slot_e state_q;

  // queued until ordering lets it out, then one far cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= ST_IDLE;
    else if (ce_i)
    begin
      case (state_q)
        ST_IDLE: if (load_i) state_q <= ST_WAIT;
        ST_WAIT: if (go_i) state_q <= ST_FAR;
        ST_FAR: if (fdone_i) state_q <= ST_DONE;
        ST_DONE: if (take_i) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // request fields, frozen for the life of the slot
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fwrite_o <= 1'b0;
      faddr_o <= '0;
      fbe_o <= '0;
      fwdata_o <= '0;
    end
    else if (ce_i && load_i && state_q == ST_IDLE)
    begin
      fwrite_o <= write_i;
      faddr_o <= addr_i;
      fbe_o <= be_i;
      fwdata_o <= wdata_i;
    end
  end

  // captured read data from the far bus
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (ce_i && state_q == ST_FAR && fdone_i)
      rdata_o <= frdata_i;
  end

  assign busy_o = state_q != ST_IDLE;
  assign done_o = state_q == ST_DONE;
  assign fvalid_o = state_q == ST_FAR;
endmodule : iobr_dt_slot
`default_nettype wire

// File: design/iobr_agent.sv
// bus agents end: initiator that repeats on retry, far bus io targets
`timescale 1ns/1ps
`default_nettype none
module iobr_agent
#(
  parameter int FAR_LAT = iobr_pkg::FAR_LAT
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  iobr_if.agt LINK
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ISSUE = 2'h1,
    ST_WAIT = 2'h3} ini_e;
  ini_e state_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [15:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [31:0] tgt_q;
  logic [31:0] cap_q;
  logic [1:0] order_q;
  logic [1:0] kind_q;
  logic subtr_q;
  logic [1:0][7:0] lat_q;

  // command registers written over the plain port
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      addr_q <= '0;
      wdata_q <= '0;
      ctrl_q <= '0;
      tgt_q <= '0;
      order_q <= 2'h3;
    end
    else if (CE_I && WR_I)
    begin
      if (ADDR_I == iobr_pkg::H_ADDR)
        addr_q <= WDATA_I;
      else if (ADDR_I == iobr_pkg::H_WDATA)
        wdata_q <= WDATA_I;
      else if (ADDR_I == iobr_pkg::H_CTRL && state_q == ST_IDLE)
        ctrl_q <= WDATA_I[15:0];
      else if (ADDR_I == iobr_pkg::H_TGT)
        tgt_q <= WDATA_I;
      else if (ADDR_I == iobr_pkg::H_ORDER)
        order_q <= WDATA_I[1:0];
    end
  end

  // issue, wait one cycle for the answer, repeat while retried
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      state_q <= ST_IDLE;
      kind_q <= '0;
      subtr_q <= 1'b0;
      rdata_q <= '0;
    end
    else if (CE_I)
    begin
      case (state_q)
        ST_IDLE:
          if (WR_I && ADDR_I == iobr_pkg::H_CTRL && WDATA_I[iobr_pkg::HC_GO])
            state_q <= ST_ISSUE;
        ST_ISSUE: state_q <= ST_WAIT;
        ST_WAIT:
          if (LINK.rsp_valid)
          begin
            kind_q <= LINK.rsp_kind;
            subtr_q <= LINK.rsp_subtr;
            rdata_q <= LINK.rsp_rdata;
            state_q <= (LINK.rsp_kind == iobr_pkg::RSP_RETRY) ?
              ST_ISSUE : ST_IDLE;
          end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign LINK.req_valid = CE_I && state_q == ST_ISSUE;
  assign LINK.req_side = ctrl_q[iobr_pkg::HC_SIDE];
  assign LINK.req_space = iobr_pkg::space_e'(ctrl_q[iobr_pkg::HC_SPACE_LO +: 2]);
  assign LINK.req_csr = ctrl_q[iobr_pkg::HC_CSR];
  assign LINK.req_write = ctrl_q[iobr_pkg::HC_WRITE];
  assign LINK.req_addr = addr_q;
  assign LINK.req_be = ctrl_q[iobr_pkg::HC_BE_LO +: 4];
  assign LINK.req_wdata = wdata_q;
  assign LINK.order_ok = order_q;

  // far bus targets complete a cycle after a fixed latency
  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : g_tgt
      always_ff @(posedge CORE_CLK_I)
      begin
        if (RST_I)
          lat_q[k] <= '0;
        else if (CE_I)
          lat_q[k] <= (LINK.far_valid[k] && !LINK.far_done[k]) ?
            lat_q[k] + 8'h01 : 8'h00;
      end
      assign LINK.far_done[k] = LINK.far_valid[k] &&
        (lat_q[k] == 8'(FAR_LAT));
      assign LINK.far_rdata[k] = tgt_q;
    end
  endgenerate

  // last far write data, downstream taking priority
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      cap_q <= '0;
    else if (CE_I && LINK.far_done[0] && LINK.far_write[0])
      cap_q <= LINK.far_wdata[0];
    else if (CE_I && LINK.far_done[1] && LINK.far_write[1])
      cap_q <= LINK.far_wdata[1];
  end

  // read data one cycle after the read strobe
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      RDATA_O <= '0;
    else if (CE_I && RD_I)
    begin
      if (ADDR_I == iobr_pkg::H_STAT)
        RDATA_O <= {28'h0, subtr_q, kind_q, state_q != ST_IDLE};
      else if (ADDR_I == iobr_pkg::H_RDATA)
        RDATA_O <= rdata_q;
      else if (ADDR_I == iobr_pkg::H_CAP)
        RDATA_O <= cap_q;
      else if (ADDR_I == iobr_pkg::H_ADDR)
        RDATA_O <= addr_q;
      else
        RDATA_O <= '0;
    end
  end
endmodule : iobr_agent
`default_nettype wire

// File: test/iobr_link_chk.sv
// link checker for the io bridge pair
`timescale 1ns/1ps
`default_nettype none
module iobr_link_chk
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic req_valid,
  input wire logic rsp_valid,
  input wire logic rsp_subtr,
  input var iobr_pkg::rsp_e rsp_kind,
  input wire logic [1:0] far_valid,
  input wire logic [1:0] far_done,
  input wire logic [1:0] order_ok,
  input wire logic [1:0][31:0] far_addr,
  input wire logic [1:0][3:0] far_be
);
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  // answers follow requests by exactly one cycle
  property p_rsp;
    req_valid |=> rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_cause;
    rsp_valid |-> $past(req_valid);
  endproperty
  a_cause: assert property (p_cause) else $error("stray answer");
  // agent repeats no faster than every other cycle
  property p_gap;
    req_valid |=> !req_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("back to back");
  // downstream far cycle holds address and lanes until it ends
  property p_hold;
    far_valid[0] && !far_done[0] |=> far_valid[0] && $stable(far_addr[0])
      && $stable(far_be[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("far moved");
  property p_order;
    !far_valid[0] && !order_ok[0] |=> !far_valid[0];
  endproperty
  a_order: assert property (p_order) else $error("out of order");
  property p_done;
    $rose(far_valid[0]) |-> ##[1:4] far_done[0];
  endproperty
  a_done: assert property (p_done) else $error("far hung");
  property p_end;
    far_done[0] |=> !far_valid[0];
  endproperty
  a_end: assert property (p_end) else $error("far reissued");
  // subtractive timing never pairs with an unclaimed answer
  property p_none;
    rsp_valid && rsp_kind == iobr_pkg::RSP_NONE |-> !rsp_subtr;
  endproperty
  a_none: assert property (p_none) else $error("bad subtr");
endmodule : iobr_link_chk
`default_nettype wire

// File: test/testbench.sv
// bench for the io bridge pair, driven through the agent registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] own;
  logic [31:0] fa [2];
  logic [3:0] fbe [2];
  int fcnt [2];
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] d;
  logic [31:0] st;
  iobr_if link();
  iobr_device iobr_device_i (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .LINK(link), .DN_OWN_O(own[0]), .UP_OWN_O(own[1]));
  iobr_agent iobr_agent_i (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .ADDR_I(ad), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .LINK(link));
  iobr_link_chk iobr_link_chk_i (.CORE_CLK_I(clk), .RST_I(rst),
    .req_valid(link.req_valid), .rsp_valid(link.rsp_valid),
    .rsp_subtr(link.rsp_subtr), .rsp_kind(link.rsp_kind),
    .far_valid(link.far_valid), .far_done(link.far_done),
    .order_ok(link.order_ok), .far_addr(link.far_addr),
    .far_be(link.far_be));
  // 50 ns clock
  always #25 clk = ~clk;
  // snoop each far cycle as it ends
  always @(posedge clk)
  begin
    for (int k = 0; k < 2; k++)
      if (link.far_done[k] === 1'b1)
      begin
        fa[k] <= link.far_addr[k];
        fbe[k] <= link.far_be[k];
        fcnt[k] <= fcnt[k] + 1;
      end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    ad <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // read data appears in the cycle after the strobe and holds until the next read
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // one link access; bounded poll, st keeps the last status
  task automatic xf(input logic w, input logic s, input logic c,
    input logic [1:0] sp, input logic [3:0] be, input logic [31:0] a,
    input logic [31:0] v);
    wreg(iobr_pkg::H_ADDR, a);
    wreg(iobr_pkg::H_WDATA, v);
    wreg(iobr_pkg::H_CTRL, {20'h0, be, 2'h0, sp, c, s, w, 1'b1});
    for (int i = 0; i < 100; i++)
    begin
      rreg(iobr_pkg::H_STAT);
      st = d;
      if (st[0] === 1'b0)
        break;
    end
    rreg(iobr_pkg::H_RDATA);
  endtask : xf
  task automatic dw(input logic s, input logic [7:0] o, input logic [31:0] v,
    input logic [3:0] be);
    xf(1'b1, s, 1'b1, 2'h1, be, {24'h0, o}, v);
  endtask : dw
  task automatic dr(input logic s, input logic [7:0] o, input logic [3:0] be);
    xf(1'b0, s, 1'b1, 2'h1, be, {24'h0, o}, 32'h0);
  endtask : dr
  task automatic t_win();
    logic [31:0] m;
    logic [31:0] a;
    dw(1'b0, iobr_pkg::OFS_DN_BAR, 32'h4000, 4'hf);
    dw(1'b0, iobr_pkg::OFS_DN_XLAT, 32'ha5a5a5a5, 4'hf);
    dw(1'b0, iobr_pkg::OFS_CTRL, 32'h4, 4'h1);
    for (int sz = 6; sz < 10; sz++)
    begin
      m = (32'h1 << sz) - 32'h1;
      a = 32'h4000 | (m & 32'h1fc);
      dw(1'b0, iobr_pkg::OFS_WSIZE, sz, 4'h1);
      xf(1'b1, 1'b0, 1'b0, 2'h1, 4'hf, a, 32'h0);
      check(fa[0], (32'ha5a5a5a5 & ~m) | (a & m));
      check({30'h0, st[2:1]}, 32'h2);
      xf(1'b1, 1'b0, 1'b0, 2'h1, 4'hf, 32'h4001 + m, 32'h0);
      check({30'h0, st[2:1]}, 32'h0);
    end
  endtask : t_win
  task automatic t_ind();
    logic [7:0] o;
    int n;
    wreg(iobr_pkg::H_TGT, 32'h12345678);
    dr(1'b0, iobr_pkg::OFS_DN_DATA, 4'hf);
    check(d, 32'h0);
    dw(1'b0, iobr_pkg::OFS_CTRL, 32'h3, 4'h1);
    for (int k = 0; k < 2; k++)
    begin
      o = k ? iobr_pkg::OFS_UP_ADDR : iobr_pkg::OFS_DN_ADDR;
      n = fcnt[k];
      dr(k[0], iobr_pkg::OFS_OWN, 4'h1 << k);
      check({31'h0, d[8*k]}, 32'h0);
      dr(k[0], iobr_pkg::OFS_OWN, 4'h1 << k);
      check({31'h0, d[8*k]}, 32'h1);
      dr(k[0], iobr_pkg::OFS_CTRL, 4'hf);
      check({31'h0, d[8+8*k]}, 32'h1);
      dw(k[0], o, 32'h302, 4'hf);
      dr(!k[0], o + 8'h4, 4'hf);
      check(d, 32'h0);
      xf(1'b0, k[0], 1'b1, 2'h0, 4'hf, {24'h0, o + 8'h4}, 32'h0);
      check(fcnt[k], n);
      dw(k[0], o + 8'h4, 32'hcc0000, 4'h4);
      check({fbe[k], fa[k][27:0]}, 32'h40000302);
      check({31'h0, own[k]}, 32'h0);
      dr(k[0], o + 8'h4, 4'hf);
      check(d, 32'h12345678);
    end
  endtask : t_ind
  // downstream lane held shut by ordering, then released
  task automatic t_ord();
    int n;
    n = fcnt[0];
    wreg(iobr_pkg::H_ORDER, 32'h2);
    dw(1'b0, iobr_pkg::OFS_DN_DATA, 32'h0, 4'hf);
    check(fcnt[0], n);
    wreg(iobr_pkg::H_ORDER, 32'h3);
    // the agent still repeats the held write; wait for it, issue nothing new
    for (int i = 0; i < 100; i++)
    begin
      rreg(iobr_pkg::H_STAT);
      if (d[0] === 1'b0)
        break;
    end
    check({30'h0, d[2:1]}, 32'h2);
    check(fcnt[0], n + 1);
  endtask : t_ord
  task automatic t_sub();
    logic [1:0] f [3] = '{2'h1, 2'h2, 2'h0};
    logic h;
    for (int i = 0; i < 3; i++)
      for (int k = 0; k < 2; k++)
      begin
        h = (f[i] == k + 1);
        dw(1'b0, iobr_pkg::OFS_CTRL, {6'h0, f[i], 24'h0}, 4'h8);
        xf(1'b1, k[0], 1'b0, 2'h1, 4'hf, 32'h77000040, 32'h0);
        check({29'h0, st[3:1]}, h ? 32'h6 : 32'h0);
        if (h)
          check(fa[k], 32'h77000040);
      end
  endtask : t_sub
  // hang guard, far beyond the fewer than a thousand cycles needed
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_win();
    t_ind();
    t_ord();
    t_sub();
    summarize();
  end
endmodule : testbench
`default_nettype wire
